// file: tdc_pkg.sv
// Package for the dual-compare 8-bit timer
package tdc_pkg;
  localparam int TDC_WIDTH = 8;
  localparam logic [7:0] TDC_MAX = 8'hff;
  localparam logic [7:0] TDC_BOTTOM = 8'h00;
  localparam logic [7:0] TDC_COUNT_RESET = 8'h00;
  localparam logic [7:0] TDC_COMPARE_RESET = 8'h00;
  localparam logic [2:0] TDC_CS_STOP = 3'h0;
  localparam logic [2:0] TDC_CS_DIV1 = 3'h1;
  localparam logic [2:0] TDC_CS_DIV8 = 3'h2;
  localparam logic [2:0] TDC_CS_DIV64 = 3'h3;
  localparam logic [2:0] TDC_CS_DIV256 = 3'h4;
  localparam logic [2:0] TDC_CS_DIV1024 = 3'h5;
  localparam logic [2:0] TDC_CS_EXT_FALL = 3'h6;
  localparam logic [2:0] TDC_CS_EXT_RISE = 3'h7;
  localparam int TDC_PRESCALE_BITS = 10;
  localparam logic [9:0] TDC_DIV8_MASK = 10'h007;
  localparam logic [9:0] TDC_DIV64_MASK = 10'h03f;
  localparam logic [9:0] TDC_DIV256_MASK = 10'h0ff;
  localparam logic [9:0] TDC_DIV1024_MASK = 10'h3ff;
  localparam int TDC_FLAG_OVF = 0;
  localparam int TDC_FLAG_CMPA = 1;
  localparam int TDC_FLAG_CMPB = 2;

  typedef struct packed {
    logic [2:0] clock_source_select;
    logic clear_on_match_mode;
  } tdc_control_t;

  typedef struct packed {
    logic compare_b;
    logic compare_a;
    logic overflow;
  } tdc_flags_t;
endpackage

// file: tdc_timer.sv
// Dual-compare 8-bit timer/counter core
`timescale 1ns/100ps
`default_nettype none

module tdc_timer #(
  parameter int PRESCALE_BITS = tdc_pkg::TDC_PRESCALE_BITS
) (
  // Clock and reset
  input wire logic clock,
  input wire logic rst,
  // Control
  input wire tdc_pkg::tdc_control_t timer_control,
  input wire logic timer_power_off,
  input wire logic global_irq_enable,
  input wire tdc_pkg::tdc_flags_t timer_mask_register,
  // Counter access
  input wire logic count_write,
  input wire logic [7:0] count_write_data,
  output logic [7:0] count_value,
  // Compare values
  input wire logic compare_a_write,
  input wire logic compare_b_write,
  input wire logic [7:0] compare_write_data,
  output logic [7:0] compare_a_value,
  output logic [7:0] compare_b_value,
  // Flags
  input wire logic flag_write,
  input wire tdc_pkg::tdc_flags_t flag_write_data,
  input wire tdc_pkg::tdc_flags_t irq_executed,
  output tdc_pkg::tdc_flags_t timer_flag_register,
  output tdc_pkg::tdc_flags_t irq_request,
  // External pin and tick
  input wire logic ext_count_pin,
  output logic timer_tick
);
  import tdc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Tick generation
  logic [PRESCALE_BITS-1:0] prescale;
  logic [PRESCALE_BITS-1:0] next_prescale;
  logic pin_sync1;
  logic pin_sync2;
  logic pin_last;
  logic tick;
  logic [PRESCALE_BITS-1:0] div_mask;
  logic enabled;

  assign enabled = !timer_power_off;

  always_comb begin
    next_prescale = enabled ? prescale + 1'b1 : '0;
    unique case (timer_control.clock_source_select)
      TDC_CS_DIV8: div_mask = PRESCALE_BITS'(TDC_DIV8_MASK);
      TDC_CS_DIV64: div_mask = PRESCALE_BITS'(TDC_DIV64_MASK);
      TDC_CS_DIV256: div_mask = PRESCALE_BITS'(TDC_DIV256_MASK);
      TDC_CS_DIV1024: div_mask = PRESCALE_BITS'(TDC_DIV1024_MASK);
      default: div_mask = '0;
    endcase
    tick = 1'b0;
    unique case (timer_control.clock_source_select)
      TDC_CS_STOP: tick = 1'b0;
      TDC_CS_DIV1: tick = 1'b1;
      TDC_CS_DIV8, TDC_CS_DIV64, TDC_CS_DIV256, TDC_CS_DIV1024:
        tick = ((prescale & div_mask) == div_mask);
      TDC_CS_EXT_FALL: tick = pin_last && !pin_sync2;
      TDC_CS_EXT_RISE: tick = !pin_last && pin_sync2;
    endcase
    tick = tick && enabled;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      prescale <= '0;
      pin_sync1 <= 1'b0;
      pin_sync2 <= 1'b0;
      pin_last <= 1'b0;
    end else begin
      prescale <= next_prescale;
      pin_sync1 <= ext_count_pin;
      pin_sync2 <= pin_sync1;
      pin_last <= pin_sync2;
    end
  end

  assign timer_tick = tick;

  ////////////////////////////////////////////////////////////////////////////
  // Counter, compares and flags
  logic [7:0] next_count;
  logic [7:0] next_cmp_a;
  logic [7:0] next_cmp_b;
  tdc_flags_t next_flags;
  logic block_match;
  logic next_block_match;
  logic match_a;
  logic match_b;
  logic at_top;
  logic wraps;

  always_comb begin
    match_a = (count_value == compare_a_value) && !block_match;
    match_b = (count_value == compare_b_value) && !block_match;
    at_top = timer_control.clear_on_match_mode ? (count_value == compare_a_value) : (count_value == TDC_MAX);
    wraps = tick && !count_write && (count_value == TDC_MAX);
    next_count = count_value;
    if (count_write) begin
      next_count = count_write_data;
    end else if (tick) begin
      if (timer_control.clear_on_match_mode && at_top) begin
        next_count = TDC_BOTTOM;
      end else begin
        next_count = count_value + 8'h01;
      end
    end
    next_block_match = block_match;
    if (count_write) begin
      next_block_match = 1'b1;
    end else if (tick) begin
      next_block_match = 1'b0;
    end
    next_cmp_a = compare_a_write ? compare_write_data : compare_a_value;
    next_cmp_b = compare_b_write ? compare_write_data : compare_b_value;
    next_flags = timer_flag_register;
    if (flag_write) begin
      next_flags = next_flags & ~flag_write_data;
    end
    next_flags = next_flags & ~(irq_executed & timer_mask_register);
    if (wraps) begin
      next_flags.overflow = 1'b1;
    end
    if (tick && match_a) begin
      next_flags.compare_a = 1'b1;
    end
    if (tick && match_b) begin
      next_flags.compare_b = 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      count_value <= TDC_COUNT_RESET;
      compare_a_value <= TDC_COMPARE_RESET;
      compare_b_value <= TDC_COMPARE_RESET;
      timer_flag_register <= '0;
      block_match <= 1'b0;
    end else begin
      count_value <= next_count;
      compare_a_value <= next_cmp_a;
      compare_b_value <= next_cmp_b;
      timer_flag_register <= next_flags;
      block_match <= next_block_match;
    end
  end

  assign irq_request = global_irq_enable ? (timer_flag_register & timer_mask_register) : '0;

  ////////////////////////////////////////////////////////////////////////////
  // Assertions
  AST_WRITE_WINS: assert property (@(posedge clock) disable iff (rst)
    count_write |=> count_value == $past(count_write_data))
    else $error("counter write not taken");
  AST_STOP_HOLDS: assert property (@(posedge clock) disable iff (rst)
    (timer_control.clock_source_select == TDC_CS_STOP && !count_write) |=> $stable(count_value))
    else $error("stopped counter moved");
  AST_WRAP: assert property (@(posedge clock) disable iff (rst)
    (tick && !count_write && !timer_control.clear_on_match_mode && count_value == TDC_MAX)
    |=> count_value == TDC_BOTTOM)
    else $error("no wrap at max");
  AST_OVF_SET: assert property (@(posedge clock) disable iff (rst)
    (tick && !count_write && count_value == TDC_MAX) |=> timer_flag_register.overflow)
    else $error("overflow flag not set");
  AST_CTC_CLEAR: assert property (@(posedge clock) disable iff (rst)
    (tick && !count_write && timer_control.clear_on_match_mode && count_value == compare_a_value)
    |=> count_value == TDC_BOTTOM)
    else $error("no clear on match");
  AST_CMPB_SET: assert property (@(posedge clock) disable iff (rst)
    (tick && !block_match && count_value == compare_b_value) |=> timer_flag_register.compare_b)
    else $error("compare b flag not set");
  sequence seq_blocked_tick;
    tick && block_match && !count_write && !timer_flag_register.compare_a;
  endsequence
  sequence seq_blocked_tick_b;
    tick && block_match && !count_write && !timer_flag_register.compare_b;
  endsequence
  AST_BLOCK: assert property (@(posedge clock) disable iff (rst)
    seq_blocked_tick |=> !timer_flag_register.compare_a)
    else $error("match not blocked");
  AST_BLOCK_B: assert property (@(posedge clock) disable iff (rst)
    seq_blocked_tick_b |=> !timer_flag_register.compare_b)
    else $error("compare b match not blocked");
  AST_BLOCK_ARM: assert property (@(posedge clock) disable iff (rst)
    count_write |=> block_match)
    else $error("counter write did not arm blocking");
  AST_BLOCK_DROP: assert property (@(posedge clock) disable iff (rst)
    (tick && !count_write) |=> !block_match)
    else $error("blocking outlived one tick");
  AST_W1C: assert property (@(posedge clock) disable iff (rst)
    (flag_write && flag_write_data.compare_b && !(tick && match_b)) |=> !timer_flag_register.compare_b)
    else $error("write one did not clear");
  AST_IRQ: assert property (@(posedge clock) disable iff (rst)
    irq_request.overflow == (global_irq_enable && timer_mask_register.overflow && timer_flag_register.overflow))
    else $error("bad overflow request");
  AST_PIN_TICK: assert property (@(posedge clock) disable iff (rst)
    (enabled && timer_control.clock_source_select == TDC_CS_EXT_RISE && tick) |=> !(tick && $stable(timer_control)))
    else $error("pin tick longer than one cycle");
  AST_CMPA_SET: assert property (@(posedge clock) disable iff (rst)
    (tick && !block_match && count_value == compare_a_value) |=> timer_flag_register.compare_a)
    else $error("compare a flag not set");
  AST_CMPA_NONE: assert property (@(posedge clock) disable iff (rst)
    (!tick && !timer_flag_register.compare_a) |=> !timer_flag_register.compare_a)
    else $error("compare a flag set without a tick");
  AST_OVF_ONLY_WRAP: assert property (@(posedge clock) disable iff (rst)
    (!timer_flag_register.overflow && !(tick && !count_write && count_value == TDC_MAX))
    |=> !timer_flag_register.overflow)
    else $error("overflow flag set without a wrap");
  AST_INC: assert property (@(posedge clock) disable iff (rst)
    (tick && !count_write && !timer_control.clear_on_match_mode && count_value != TDC_MAX)
    |=> count_value == $past(count_value) + 8'h01)
    else $error("free-running counter did not step");
  AST_CTC_INC: assert property (@(posedge clock) disable iff (rst)
    (tick && !count_write && timer_control.clear_on_match_mode && count_value != compare_a_value)
    |=> count_value == $past(count_value) + 8'h01)
    else $error("counter did not step below or above top");
  AST_CMPA_WRITE: assert property (@(posedge clock) disable iff (rst)
    compare_a_write |=> compare_a_value == $past(compare_write_data))
    else $error("compare a write not taken");
  AST_CMPB_WRITE: assert property (@(posedge clock) disable iff (rst)
    compare_b_write |=> compare_b_value == $past(compare_write_data))
    else $error("compare b write not taken");
  AST_W1C_A: assert property (@(posedge clock) disable iff (rst)
    (flag_write && flag_write_data.compare_a && !(tick && match_a)) |=> !timer_flag_register.compare_a)
    else $error("write one did not clear compare a");
  AST_W1C_OVF: assert property (@(posedge clock) disable iff (rst)
    (flag_write && flag_write_data.overflow && !wraps) |=> !timer_flag_register.overflow)
    else $error("write one did not clear overflow");
  AST_W0_KEEP: assert property (@(posedge clock) disable iff (rst)
    (flag_write && !flag_write_data.overflow && timer_flag_register.overflow
      && !(irq_executed.overflow && timer_mask_register.overflow)) |=> timer_flag_register.overflow)
    else $error("write zero cleared overflow");
  AST_EXEC_CLEARS: assert property (@(posedge clock) disable iff (rst)
    (irq_executed.compare_a && timer_mask_register.compare_a && !(tick && match_a)) |=> !timer_flag_register.compare_a)
    else $error("executed interrupt left compare a set");
  AST_EXEC_OVF: assert property (@(posedge clock) disable iff (rst)
    (irq_executed.overflow && timer_mask_register.overflow && !wraps) |=> !timer_flag_register.overflow)
    else $error("executed interrupt left overflow set");
  AST_EXEC_MASKED: assert property (@(posedge clock) disable iff (rst)
    (irq_executed.compare_b && !timer_mask_register.compare_b && timer_flag_register.compare_b
      && !(flag_write && flag_write_data.compare_b)) |=> timer_flag_register.compare_b)
    else $error("disabled interrupt cleared compare b");
  AST_IRQ_A: assert property (@(posedge clock) disable iff (rst)
    irq_request.compare_a == (global_irq_enable && timer_mask_register.compare_a && timer_flag_register.compare_a))
    else $error("bad compare a request");
  AST_IRQ_B: assert property (@(posedge clock) disable iff (rst)
    irq_request.compare_b == (global_irq_enable && timer_mask_register.compare_b && timer_flag_register.compare_b))
    else $error("bad compare b request");
  AST_OFF_NO_TICK: assert property (@(posedge clock) disable iff (rst)
    timer_power_off |-> !timer_tick)
    else $error("tick while powered off");
  AST_PRESCALE_HELD: assert property (@(posedge clock) disable iff (rst)
    timer_power_off |=> (prescale == '0))
    else $error("prescaler ran while powered off");
  AST_DIV1_TICK: assert property (@(posedge clock) disable iff (rst)
    (!timer_power_off && timer_control.clock_source_select == TDC_CS_DIV1) |-> tick)
    else $error("undivided source gave no tick");
  AST_DIV8_GAP: assert property (@(posedge clock) disable iff (rst)
    (tick && timer_control.clock_source_select == TDC_CS_DIV8 && !timer_power_off)
    |=> (!tick || timer_control.clock_source_select != TDC_CS_DIV8) [*7])
    else $error("divide by eight ticked early");
  sequence seq_pin_rise;
    !ext_count_pin ##1 ext_count_pin;
  endsequence
  sequence seq_pin_fall;
    ext_count_pin ##1 !ext_count_pin;
  endsequence
  AST_PIN_RISE: assert property (@(posedge clock) disable iff (rst)
    seq_pin_rise |-> ##2 (tick || timer_control.clock_source_select != TDC_CS_EXT_RISE || timer_power_off))
    else $error("pin rise gave no tick");
  AST_PIN_FALL: assert property (@(posedge clock) disable iff (rst)
    seq_pin_fall |-> ##2 (tick || timer_control.clock_source_select != TDC_CS_EXT_FALL || timer_power_off))
    else $error("pin fall gave no tick");
endmodule
`default_nettype wire

// file: tdc_pin_model.sv
// External count pin driver for the timer bench
`timescale 1ns/100ps
`default_nettype none
module tdc_pin_model (
  // Clock and control
  input wire logic clock,
  input wire logic enable,
  // Pin
  output logic pin
);
  logic [1:0] phase = 2'h0;
  initial pin = 1'b0;
  always @(posedge clock) begin
    if (enable) begin
      phase <= phase + 2'h1;
      if (phase == 2'h3) begin
        pin <= ~pin;
      end
    end
  end
endmodule
`default_nettype wire

// file: tdc_timer_tb_top.sv
// Self-checking bench for the dual-compare timer
`timescale 1ns/100ps
`default_nettype none
module tdc_timer_tb_top;
  import tdc_pkg::*;
  logic clock = 1'b0;
  logic rst = 1'b1;
  tdc_control_t ctl = '0;
  tdc_flags_t mask = '0;
  tdc_flags_t fwd = '0;
  tdc_flags_t iexe = '0;
  tdc_flags_t flags;
  tdc_flags_t irq;
  logic pwr = 1'b1;
  logic gie = 1'b0;
  logic cw = 1'b0;
  logic caw = 1'b0;
  logic cbw = 1'b0;
  logic fw = 1'b0;
  logic pen = 1'b0;
  logic pin;
  logic tick;
  logic [7:0] cwd = 8'h00;
  logic [7:0] cnt;
  logic [7:0] cav;
  logic [7:0] cbv;
  int fail_count = 0;
  int samples_checked = 0;
  initial begin
    forever #12.5 clock = ~clock;
  end
  tdc_timer tdc_timer_i (.clock(clock), .rst(rst), .timer_control(ctl), .timer_power_off(pwr),
    .global_irq_enable(gie), .timer_mask_register(mask), .count_write(cw), .count_write_data(cwd),
    .count_value(cnt), .compare_a_write(caw), .compare_b_write(cbw), .compare_write_data(cwd),
    .compare_a_value(cav), .compare_b_value(cbv), .flag_write(fw), .flag_write_data(fwd),
    .irq_executed(iexe), .timer_flag_register(flags), .irq_request(irq), .ext_count_pin(pin),
    .timer_tick(tick));
  tdc_pin_model tdc_pin_model_i (.clock(clock), .enable(pen), .pin(pin));
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chf(input logic [2:0] e);
    chk({5'h0, flags}, {5'h0, e});
  endtask
  // Write strobe: 0 count, 1 compare A, 2 compare B, 3 flags
  task automatic wr(input int sel, input logic [7:0] v);
    cyc(1);
    {cw, caw, cbw, fw} <= {sel == 0, sel == 1, sel == 2, sel == 3};
    cwd <= v;
    fwd <= v[2:0];
    cyc(1);
    {cw, caw, cbw, fw} <= 4'h0;
  endtask
  task automatic run(input logic [2:0] cs, input logic clear_on_match, input int n);
    cyc(1);
    ctl <= '{cs, clear_on_match};
    cyc(n);
    ctl <= '{TDC_CS_STOP, clear_on_match};
  endtask
  task automatic t_stop();
    wr(0, 8'h5a);
    run(TDC_CS_DIV1, 1'b0, 8);
    #1 chk(cnt, 8'h5a);
    cyc(1);
    pwr <= 1'b0;
    cyc(8);
    #1 chk(cnt, 8'h5a);
    chk({7'h0, tick}, 8'h00);
    cyc(1);
    ctl <= '{TDC_CS_DIV1, 1'b0};
    #1 chk({7'h0, tick}, 8'h01);
    cyc(1);
    ctl <= '{TDC_CS_STOP, 1'b0};
    #1 chk(cnt, 8'h5b);
    $display("test stop done");
  endtask
  task automatic t_wrap();
    wr(0, 8'hfe);
    run(TDC_CS_DIV1, 1'b0, 2);
    #1 chk(cnt, TDC_BOTTOM);
    chf(3'b001);
    wr(3, 8'h00);
    #1 chf(3'b001);
    wr(3, 8'h01);
    #1 chf(3'b000);
    $display("test wrap done");
  endtask
  task automatic t_cmpb();
    wr(2, 8'h10);
    wr(0, 8'h0f);
    run(TDC_CS_DIV1, 1'b0, 2);
    #1 chf(3'b100);
    chk(cnt, 8'h11);
    wr(3, 8'h07);
    wr(0, 8'h10);
    cyc(5);
    run(TDC_CS_DIV1, 1'b0, 1);
    #1 chf(3'b000);
    chk(cnt, 8'h11);
    $display("test compare b done");
  endtask
  task automatic t_ctc();
    wr(1, 8'h03);
    wr(0, 8'h00);
    run(TDC_CS_DIV1, 1'b1, 4);
    #1 chk(cnt, TDC_BOTTOM);
    chf(3'b010);
    chk(cav, 8'h03);
    wr(3, 8'h07);
    wr(0, 8'h05);
    run(TDC_CS_DIV1, 1'b1, 254);
    #1 chk(cnt, 8'h03);
    chf(3'b101);
    run(TDC_CS_DIV1, 1'b1, 1);
    #1 chk(cnt, TDC_BOTTOM);
    chf(3'b111);
    $display("test clear on match done");
  endtask
  task automatic t_irq();
    cyc(1);
    mask <= 3'b011;
    gie <= 1'b1;
    cyc(1);
    #1 chk({5'h0, irq}, 8'h03);
    cyc(1);
    gie <= 1'b0;
    cyc(1);
    #1 chk({5'h0, irq}, 8'h00);
    cyc(1);
    iexe <= 3'b110;
    cyc(1);
    iexe <= 3'b000;
    #1 chf(3'b101);
    cyc(1);
    iexe <= 3'b001;
    cyc(1);
    iexe <= 3'b000;
    #1 chf(3'b100);
    $display("test interrupt done");
  endtask
  task automatic t_pre();
    logic [7:0] exp [4] = '{8'h80, 8'h10, 8'h04, 8'h01};
    for (int i = 0; i < 4; i++) begin
      wr(0, 8'h00);
      run(TDC_CS_DIV8 + 3'(i), 1'b0, 1024);
      #1 chk(cnt, exp[i]);
    end
    $display("test prescaler done");
  endtask
  task automatic t_ext();
    wr(0, 8'h00);
    for (int i = 0; i < 2; i++) begin
      cyc(1);
      ctl <= '{TDC_CS_EXT_RISE - 3'(i), 1'b0};
      pen <= 1'b1;
      cyc(32);
      pen <= 1'b0;
      cyc(6);
      #1 chk(cnt, 8'(4 * (i + 1)));
    end
    $display("test external pin done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  initial begin
    cyc(4);
    rst <= 1'b0;
    #1 chk(cnt, TDC_COUNT_RESET);
    chk(cbv, TDC_COMPARE_RESET);
    chf(3'b000);
    t_stop();
    t_wrap();
    t_cmpb();
    t_ctc();
    t_irq();
    t_pre();
    t_ext();
    report_and_stop();
  end
endmodule
`default_nettype wire
